// ### verilog/pmaab_pkg.sv
// Constants for the PMA ability and test control register bank.
package pmaab_pkg;
    localparam logic [4:0] PMAAB_DEV_PMA = 5'h01;
    localparam logic [15:0] PMAAB_OFS_EXT1 = 16'h000b;
    localparam logic [15:0] PMAAB_OFS_EXT2 = 16'h0012;
    localparam logic [15:0] PMAAB_OFS_ROLE = 16'h0834;
    localparam logic [15:0] PMAAB_OFS_TEST = 16'h0836;
    localparam logic [15:0] PMAAB_EXT1_VAL = 16'h0800;
    localparam logic [15:0] PMAAB_EXT2_VAL = 16'h0001;
    localparam logic [15:0] PMAAB_ROLE_FIXED = 16'h8000;
    localparam logic [15:0] PMAAB_TEST_FIXED = 16'h0001;
    localparam int PMAAB_ROLE_BIT = 14;
    localparam int PMAAB_TEST_LSB = 12;
    localparam int PMAAB_TEST_MSB = 15;
    localparam logic [1:0] PMAAB_SEL_NONE = 2'h0;

    typedef enum logic [3:0] {
        PMAAB_TM_NORMAL = 4'b0000,
        PMAAB_TM_MODE1 = 4'b0010,
        PMAAB_TM_MODE2 = 4'b0100,
        PMAAB_TM_MODE4 = 4'b1000,
        PMAAB_TM_MODE5 = 4'b1010
    } pmaab_tmode_t;

    typedef enum logic [2:0] {
        PMAAB_R_NONE = 3'b000,
        PMAAB_R_EXT1 = 3'b001,
        PMAAB_R_EXT2 = 3'b010,
        PMAAB_R_ROLE = 3'b011,
        PMAAB_R_TEST = 3'b100
    } pmaab_reg_t;
endpackage

// ### verilog/pmaab_rd_if.sv
// Read path signals between the register bank and its read multiplexer.
`timescale 1ns/1ps
interface pmaab_rd_if;
    import pmaab_pkg::*;
    pmaab_reg_t sel;
    logic role;
    logic [3:0] test_mode;
    logic [15:0] rdata;
    modport bank (output sel, output role, output test_mode, input rdata);
    modport mux (input sel, input role, input test_mode, output rdata);
endinterface

// ### verilog/pmaab_rd_mux.sv
// Read data multiplexer that assembles each register word.
`timescale 1ns/1ps
module pmaab_rd_mux
    import pmaab_pkg::*;
(
    pmaab_rd_if.mux rd
);
    logic [15:0] role_word;
    logic [15:0] test_word;

    // (RULE7) Fixed bits kept.
    assign role_word = PMAAB_ROLE_FIXED |
        (16'(rd.role) << PMAAB_ROLE_BIT);
    assign test_word = PMAAB_TEST_FIXED |
        (16'(rd.test_mode) << PMAAB_TEST_LSB);

    always_comb begin
        case (rd.sel)
            // (RULE3) Reserved bits zero.
            PMAAB_R_EXT1: rd.rdata = PMAAB_EXT1_VAL;
            // (RULE4) Ability two word.
            PMAAB_R_EXT2: rd.rdata = PMAAB_EXT2_VAL;
            PMAAB_R_ROLE: rd.rdata = role_word;
            PMAAB_R_TEST: rd.rdata = test_word;
            default: rd.rdata = 16'h0000;
        endcase
    end
endmodule // pmaab_rd_mux

// ### verilog/pmaab_bank.sv
// PMA ability, role and transmitter test mode register bank.
//
// How it works
// (RULE1) The host selects management device 1 before any access here.
// (RULE2) Extended ability one bit 11 always reads 1.
// (RULE3) Extended ability one bits 15:12 and 10:0 always read 0.
// (RULE4) Extended ability two reads 1 in bit 0 and 0 in bits 15:1.
// (RULE5) Role control bit 14 is writable, 1 master, reset from a strap.
// (RULE6) Test control bits 15:12 pick the test mode, reset from a strap.
// (RULE7) Writes to fixed or reserved fields change nothing.
`timescale 1ns/1ps
module pmaab_bank
    import pmaab_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_strap_master,
    input wire logic [3:0] i_strap_test_mode,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [4:0] i_management_device_select,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic o_ack,
    output logic [15:0] o_rdata,
    output logic o_role_master,
    output logic [3:0] o_test_mode
);
    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic dev_hit;
    logic hit_role;
    logic hit_test;
    logic wr_role;
    logic wr_test;
    logic tm_legal;
    logic [3:0] wr_tm;
    pmaab_reg_t sel;
    logic role_reg;
    logic role_next;
    logic [3:0] test_reg;
    logic [3:0] test_next;
    logic ack_reg;
    logic [15:0] rdata_reg;
    pmaab_rd_if rd ();

    // Device select gate.
    // (RULE1) Device one gate.
    assign dev_hit = (i_management_device_select == PMAAB_DEV_PMA);
    assign hit_role = dev_hit && (i_addr == PMAAB_OFS_ROLE);
    assign hit_test = dev_hit && (i_addr == PMAAB_OFS_TEST);
    // (RULE7) Writable fields only.
    assign wr_role = i_req && i_we && hit_role;
    assign wr_test = i_req && i_we && hit_test;
    assign wr_tm = i_wdata[PMAAB_TEST_MSB:PMAAB_TEST_LSB];
    assign tm_legal = (wr_tm == PMAAB_TM_NORMAL) ||
        (wr_tm == PMAAB_TM_MODE1) || (wr_tm == PMAAB_TM_MODE2) ||
        (wr_tm == PMAAB_TM_MODE4) || (wr_tm == PMAAB_TM_MODE5);
    assign sel = !dev_hit ? PMAAB_R_NONE :
        (i_addr == PMAAB_OFS_EXT1) ? PMAAB_R_EXT1 :
        (i_addr == PMAAB_OFS_EXT2) ? PMAAB_R_EXT2 :
        hit_role ? PMAAB_R_ROLE :
        hit_test ? PMAAB_R_TEST : PMAAB_R_NONE;

    // ----------------------------------------------------------------
    // Writable fields
    // ----------------------------------------------------------------
    // (RULE5) Role bit write.
    assign role_next = wr_role ? i_wdata[PMAAB_ROLE_BIT] : role_reg;
    // (RULE6) Test mode write.
    assign test_next = (wr_test && tm_legal) ? wr_tm : test_reg;

    // (RULE5) Strap loaded role.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            role_reg <= i_strap_master;
        end else if (i_ce) begin
            role_reg <= role_next;
        end
    end

    // (RULE6) Strap loaded mode.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            test_reg <= i_strap_test_mode;
        end else if (i_ce) begin
            test_reg <= test_next;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    assign rd.sel = sel;
    assign rd.role = role_reg;
    assign rd.test_mode = test_reg;

    // (RULE2) Fixed ability words.
    pmaab_rd_mux u_mux (
        .rd(rd.mux)
    );

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else if (i_ce) begin
            ack_reg <= i_req;
            rdata_reg <= (i_req && !i_we) ? rd.rdata : 16'h0000;
        end
    end

    assign o_ack = ack_reg;
    assign o_rdata = rdata_reg;
    assign o_role_master = role_reg;
    assign o_test_mode = test_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic rd_ext1;
    logic rd_ext2;
    logic rd_role;
    logic rd_test;
    assign rd_ext1 = i_ce && i_req && !i_we && dev_hit &&
        (i_addr == PMAAB_OFS_EXT1);
    assign rd_ext2 = i_ce && i_req && !i_we && dev_hit &&
        (i_addr == PMAAB_OFS_EXT2);
    assign rd_role = i_ce && i_req && !i_we && hit_role;
    assign rd_test = i_ce && i_req && !i_we && hit_test;

    sequence s_role_write;
        i_ce && wr_role;
    endsequence

    sequence s_role_read;
        i_ce && i_req && !i_we && hit_role;
    endsequence

    property p_dev_gate;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_req && !dev_hit) |=> (o_rdata == 16'h0000) && o_ack;
    endproperty
    a_dev_gate: assert property (p_dev_gate) // RULE1
        else $error("Access to another device returned data.");

    property p_ext1_bit11;
        @(posedge i_clk) disable iff (!i_nrst)
        rd_ext1 |=> o_rdata[11] == 1'b1;
    endproperty
    a_ext1_bit11: assert property (p_ext1_bit11) // RULE2
        else $error("Extended ability bit 11 did not read 1.");

    property p_ext1_zero;
        @(posedge i_clk) disable iff (!i_nrst)
        rd_ext1 |=> (o_rdata[15:12] == 4'h0) && (o_rdata[10:0] == 11'h000);
    endproperty
    a_ext1_zero: assert property (p_ext1_zero) // RULE3
        else $error("Extended ability one reserved bits not zero.");

    property p_ext2_word;
        @(posedge i_clk) disable iff (!i_nrst)
        rd_ext2 |=> o_ack && (o_rdata == 16'h0001);
    endproperty
    a_ext2_word: assert property (p_ext2_word) // RULE4
        else $error("Extended ability two word is wrong.");

    property p_role_wr_rd;
        @(posedge i_clk) disable iff (!i_nrst)
        s_role_write ##1 s_role_read |=>
            o_rdata[14] == $past(i_wdata[14], 2);
    endproperty
    a_role_wr_rd: assert property (p_role_wr_rd) // RULE5
        else $error("Role bit did not read back as written.");

    property p_role_out;
        @(posedge i_clk) disable iff (!i_nrst)
        s_role_write |=> o_role_master == $past(i_wdata[14]);
    endproperty
    a_role_out: assert property (p_role_out) // RULE5
        else $error("Role output did not follow the write.");

    property p_test_legal;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && wr_test && tm_legal) |=> o_test_mode == $past(wr_tm);
    endproperty
    a_test_legal: assert property (p_test_legal) // RULE6
        else $error("Test mode did not take a legal code.");

    property p_test_read;
        @(posedge i_clk) disable iff (!i_nrst)
        rd_test |=> (o_rdata[15:12] == $past(o_test_mode)) &&
            (o_rdata[11:0] == 12'h001);
    endproperty
    a_test_read: assert property (p_test_read) // RULE6
        else $error("Test control read is wrong.");

    property p_fixed_bits;
        @(posedge i_clk) disable iff (!i_nrst)
        rd_role |=> (o_rdata[15] == 1'b1) && (o_rdata[13:0] == 14'h0000);
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) // RULE7
        else $error("Role control fixed bits changed.");

    property p_role_hold;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && !(i_req && i_we && (i_addr == PMAAB_OFS_ROLE) &&
            (i_management_device_select == PMAAB_DEV_PMA))) |=>
            $stable(o_role_master);
    endproperty
    a_role_hold: assert property (p_role_hold) // RULE7
        else $error("Role bit moved without a role write.");

    property p_test_hold;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && !(i_req && i_we && (i_addr == PMAAB_OFS_TEST) &&
            (i_management_device_select == PMAAB_DEV_PMA))) |=>
            $stable(o_test_mode);
    endproperty
    a_test_hold: assert property (p_test_hold) // RULE7
        else $error("Test mode moved without a test write.");

    property p_freeze;
        @(posedge i_clk) disable iff (!i_nrst)
        !i_ce |=> $stable(o_role_master) && $stable(o_test_mode) &&
            $stable(o_ack);
    endproperty
    a_freeze: assert property (p_freeze) // RULE7
        else $error("State moved while clock enable was low.");
endmodule // pmaab_bank

// ### bench/pmaab_bank_tb.sv
// Self-checking testbench for the PMA ability and test register bank.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t mismatch got %h exp %h", $time, a, b); end end
module pmaab_bank_tb;
    import pmaab_pkg::*;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_ce = 1'b1;
    logic i_strap_master = 1'b1;
    logic [3:0] i_strap_test_mode = 4'b0100;
    logic i_req = 1'b0;
    logic i_we = 1'b0;
    logic [4:0] i_management_device_select = 5'h01;
    logic [15:0] i_addr = 16'h0000;
    logic [15:0] i_wdata = 16'h0000;
    logic o_ack;
    logic [15:0] o_rdata;
    logic o_role_master;
    logic [3:0] o_test_mode;
    int errors = 0;
    int cmp_count = 0;
    logic [15:0] rd;
    pmaab_tmode_t modes [5] = '{PMAAB_TM_NORMAL, PMAAB_TM_MODE1,
        PMAAB_TM_MODE2, PMAAB_TM_MODE4, PMAAB_TM_MODE5};
    pmaab_bank dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_strap_master(i_strap_master),
        .i_strap_test_mode(i_strap_test_mode), .i_req(i_req), .i_we(i_we),
        .i_management_device_select(i_management_device_select),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_ack(o_ack),
        .o_rdata(o_rdata), .o_role_master(o_role_master),
        .o_test_mode(o_test_mode));
    always #20 i_clk = ~i_clk;
    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    task automatic finish_test();
        $display("Counts: %0d compares, %0d errors", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic acc(input logic we, input logic [4:0] dev,
        input logic [15:0] adr, input logic [15:0] wd);
        @(negedge i_clk);
        i_req = 1'b1;
        i_we = we;
        i_management_device_select = dev;
        i_addr = adr;
        i_wdata = wd;
        @(negedge i_clk);
        i_req = 1'b0;
        `CHK(o_ack, 1'b1)
        rd = o_rdata;
    endtask
    task automatic do_reset(input logic m, input logic [3:0] tm);
        @(negedge i_clk);
        i_nrst = 1'b0;
        i_strap_master = m;
        i_strap_test_mode = tm;
        repeat (6) @(negedge i_clk);
        i_nrst = 1'b1;
    endtask
    task automatic t_reset();
        do_reset(1'b1, 4'b0100);
        acc(1'b0, 5'h01, PMAAB_OFS_ROLE, 16'h0000);
        `CHK(rd, 16'hc000)
        acc(1'b0, 5'h01, PMAAB_OFS_TEST, 16'h0000);
        `CHK(rd, 16'h4001)
        do_reset(1'b0, 4'b0000);
        acc(1'b0, 5'h01, PMAAB_OFS_ROLE, 16'h0000);
        `CHK(rd, 16'h8000)
        `CHK(o_test_mode, 4'b0000)
        $display("test reset done");
    endtask
    task automatic t_ability();
        acc(1'b1, 5'h01, PMAAB_OFS_EXT1, 16'hffff);
        acc(1'b1, 5'h01, PMAAB_OFS_EXT2, 16'hfffe);
        acc(1'b0, 5'h01, PMAAB_OFS_EXT1, 16'h0000);
        `CHK(rd, 16'h0800)
        acc(1'b0, 5'h01, PMAAB_OFS_EXT2, 16'h0000);
        `CHK(rd, 16'h0001)
        $display("test ability done");
    endtask
    task automatic t_role();
        acc(1'b1, 5'h01, PMAAB_OFS_ROLE, 16'hffff);
        `CHK(o_role_master, 1'b1)
        acc(1'b0, 5'h01, PMAAB_OFS_ROLE, 16'h0000);
        `CHK(rd, 16'hc000)
        acc(1'b1, 5'h01, PMAAB_OFS_ROLE, 16'h0000);
        acc(1'b0, 5'h01, PMAAB_OFS_ROLE, 16'h0000);
        `CHK(rd, 16'h8000)
        `CHK(o_role_master, 1'b0)
        $display("test role done");
    endtask
    task automatic t_modes();
        foreach (modes[k]) begin
            acc(1'b1, 5'h01, PMAAB_OFS_TEST, {modes[k], 12'hfff});
            acc(1'b0, 5'h01, PMAAB_OFS_TEST, 16'h0000);
            `CHK(rd, {modes[k], 12'h001})
            `CHK(o_test_mode, modes[k])
        end
        acc(1'b1, 5'h01, PMAAB_OFS_TEST, 16'hf000);
        `CHK(o_test_mode, PMAAB_TM_MODE5)
        $display("test modes done");
    endtask
    task automatic t_select();
        acc(1'b1, 5'h02, PMAAB_OFS_ROLE, 16'h4000);
        `CHK(o_role_master, 1'b0)
        acc(1'b0, 5'h02, PMAAB_OFS_TEST, 16'h0000);
        `CHK(rd, 16'h0000)
        acc(1'b0, 5'h01, 16'h0835, 16'h0000);
        `CHK(rd, 16'h0000)
        @(negedge i_clk);
        i_ce = 1'b0;
        i_req = 1'b1;
        i_we = 1'b1;
        i_management_device_select = 5'h01;
        i_addr = PMAAB_OFS_ROLE;
        i_wdata = 16'h4000;
        repeat (2) @(negedge i_clk);
        `CHK(o_ack, 1'b0)
        i_req = 1'b0;
        i_ce = 1'b1;
        @(negedge i_clk);
        `CHK(o_role_master, 1'b0)
        $display("test select done");
    endtask
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        t_reset();
        t_ability();
        t_role();
        t_modes();
        t_select();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        $display("[FAIL] %0t run limit reached", $time);
        finish_test();
    end
endmodule // pmaab_bank_tb
